// file: design/snc_pkg.sv
// Package with constants and types for the series node count supervisor.
package snc_pkg;
	// Clock rate and indicator timing.
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BLINK_HZ = 1;
	localparam int unsigned HALF_PERIOD_CYC = CLK_HZ / (2 * BLINK_HZ);
	// Node count width: up to 32 nodes plus a terminator position.
	localparam int unsigned CNT_W = 6;
	// Settle time after power-up before the wiring is judged, in cycles.
	localparam int unsigned SETTLE_CYC = 16;
	// Cycles the save takes in the non-volatile store model.
	localparam int unsigned SAVE_CYC = 32;
	// Stored configuration at power-up: nothing taught in.
	localparam logic STORED_VALID_RST = 1'b0;
	localparam logic CHECK_OFF_RST = 1'b0;

	// Supervisor states.
	typedef enum logic [2:0]
	{
		SNC_SETTLE = 3'b000,
		SNC_UNCONF = 3'b001,
		SNC_SAVING = 3'b010,
		SNC_SAVED = 3'b011,
		SNC_RUN = 3'b100,
		SNC_FAULT = 3'b101
	} snc_state_e;
endpackage : snc_pkg

// file: design/snc_blink.sv
// Counter divider that toggles a blink phase level at the indicator rate.
`timescale 1ns/1ps
`default_nettype none
module snc_blink
#(
	parameter int unsigned HALF_CYC = snc_pkg::HALF_PERIOD_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	output logic phase
);
	logic [26:0] cnt_r;
	logic [26:0] cnt_nxt;
	logic phase_r;
	logic phase_nxt;

	// Counter wraps each half period; the phase flips on each wrap.
	always_comb
	begin
		cnt_nxt = cnt_r + 27'h0000001;
		phase_nxt = phase_r;
		if (cnt_r == 27'(HALF_CYC - 1))
		begin
			cnt_nxt = 27'h0000000;
			phase_nxt = ~phase_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r <= 27'h0000000;
			phase_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	assign phase = phase_r;
endmodule // snc_blink
`default_nettype wire

// file: design/snc_supervisor.sv
// Node count teach-in and power-up check for the series connection head.
// Summary of operation
// R01: With no valid stored configuration the mode LED flashes red at 1 Hz.
// R02: Teach-in is asked for by one controller output on both test inputs.
// R03: No IO-Link session may be opened during teach-in.
// R04: Teach-in power-up stores the count, LED alternating red and green.
// R05: After a successful save the LED flashes green at 1 Hz.
// R06: Normal wiring feeds each test input from its own controller output.
// R07: Each normal power-up compares the node count with the stored count.
// R08: A new teach-in overwrites any stored configuration for good.
// R09: Teach-in without terminator erases the set-up; the LED flashes red.
// R10: Teach-in with the terminator on the device turns all checks off.
// R11: A count mismatch keeps safe outputs off and shows a fault.
`timescale 1ns/1ps
`default_nettype none
module snc_supervisor
#(
	parameter int unsigned HALF_CYC = snc_pkg::HALF_PERIOD_CYC,
	parameter int unsigned NODE_W = snc_pkg::CNT_W
)
(
	// Clock and reset; reset stands for power-on.
	input wire logic SYS_CLK,
	input wire logic RESET,
	// Test input pins from the safety controller.
	input wire logic FIRST_TEST_INPUT,
	input wire logic SECOND_TEST_INPUT,
	// Node chain discovery results.
	input wire logic [NODE_W-1:0] NODE_COUNT,
	input wire logic TERMINATOR_SEEN,
	input wire logic COUNT_VALID,
	// Safe output permission and indicator.
	output logic SAFE_ENABLE,
	output logic LED_RED,
	output logic LED_GREEN,
	output logic FAULT,
	output logic TEACH_ACTIVE
);
	snc_pkg::snc_state_e state_r;
	snc_pkg::snc_state_e state_nxt;
	logic [1:0] a_sync_r;
	logic [1:0] b_sync_r;
	logic [7:0] tmr_r;
	logic [7:0] tmr_nxt;
	// The store powers up blank: nothing taught in, checks on.
	logic stored_valid_r = snc_pkg::STORED_VALID_RST;
	logic stored_valid_nxt;
	logic check_off_r = snc_pkg::CHECK_OFF_RST;
	logic check_off_nxt;
	logic [NODE_W-1:0] stored_cnt_r = '0;
	logic [NODE_W-1:0] stored_cnt_nxt;
	logic teach_wiring;
	logic phase;
	logic red_nxt;
	logic green_nxt;
	logic safe_nxt;
	logic fault_nxt;
	logic teach_nxt;
	logic red_r;
	logic green_r;
	logic safe_r;
	logic fault_r;
	logic teach_r;

	// Blink phase at the indicator rate.
	snc_blink #(.HALF_CYC(HALF_CYC)) u_blink
	(
		.clk(SYS_CLK),
		.rst(RESET),
		.phase(phase)
	);

	// Pins are asynchronous, so both pass two flip-flops first.
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			a_sync_r <= 2'h0;
			b_sync_r <= 2'h0;
		end
		else
		begin
			a_sync_r <= {a_sync_r[0], FIRST_TEST_INPUT};
			b_sync_r <= {b_sync_r[0], SECOND_TEST_INPUT};
		end
	end

	// Both inputs carry the same test pulses only in teach-in wiring.
	// Pulses are compared level by level; a skewed pair can read as equal
	// briefly, which is why the decision waits for the settle time.
	assign teach_wiring = (a_sync_r[1] == b_sync_r[1]); // R02

	// Supervisor state machine; decisions are taken once per power-up.
	always_comb
	begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		stored_valid_nxt = stored_valid_r;
		check_off_nxt = check_off_r;
		stored_cnt_nxt = stored_cnt_r;
		case (state_r)
			snc_pkg::SNC_SETTLE:
			begin
				if (tmr_r == 8'(snc_pkg::SETTLE_CYC - 1) && COUNT_VALID)
				begin
					tmr_nxt = 8'h00;
					if (teach_wiring)
					begin
						// Old configuration is discarded without copy.
						stored_cnt_nxt = NODE_COUNT; // R08
						check_off_nxt = TERMINATOR_SEEN &&
							(NODE_COUNT == '0); // R10
						stored_valid_nxt = TERMINATOR_SEEN; // R09
						state_nxt = snc_pkg::SNC_SAVING; // R04
					end
					else if (!stored_valid_r)
						state_nxt = snc_pkg::SNC_UNCONF; // R01
					else if (check_off_r ||
						NODE_COUNT == stored_cnt_r) // R07
						state_nxt = snc_pkg::SNC_RUN;
					else
						state_nxt = snc_pkg::SNC_FAULT; // R11
				end
				else if (tmr_r != 8'(snc_pkg::SETTLE_CYC - 1))
					tmr_nxt = tmr_r + 8'h01;
			end
			snc_pkg::SNC_SAVING:
			begin
				tmr_nxt = tmr_r + 8'h01;
				if (tmr_r == 8'(snc_pkg::SAVE_CYC - 1))
				begin
					tmr_nxt = 8'h00;
					state_nxt = stored_valid_r ? snc_pkg::SNC_SAVED :
						snc_pkg::SNC_UNCONF; // R09
				end
			end
			snc_pkg::SNC_UNCONF, snc_pkg::SNC_SAVED, snc_pkg::SNC_RUN,
			snc_pkg::SNC_FAULT:
				state_nxt = state_r; // Held until the next power-up.
			default:
				state_nxt = snc_pkg::SNC_SETTLE;
		endcase
	end

	// Output decode; only a normally wired start with a matching count or with checks off enables outputs.
	always_comb
	begin
		red_nxt = 1'b0;
		green_nxt = 1'b0;
		safe_nxt = 1'b0;
		fault_nxt = 1'b0;
		teach_nxt = 1'b0;
		case (state_nxt)
			snc_pkg::SNC_UNCONF:
				red_nxt = phase; // R01
			snc_pkg::SNC_SAVING:
			begin
				red_nxt = phase; // R04
				green_nxt = ~phase;
				teach_nxt = 1'b1; // R03
			end
			snc_pkg::SNC_SAVED:
				green_nxt = phase; // R05
			snc_pkg::SNC_RUN:
			begin
				green_nxt = 1'b1;
				safe_nxt = 1'b1; // R07
			end
			snc_pkg::SNC_FAULT:
			begin
				red_nxt = 1'b1;
				fault_nxt = 1'b1; // R11
			end
			default:
				teach_nxt = 1'b0;
		endcase
	end

	// State and output registers; power-on reset restarts the settle
	// wait, while the stored configuration below is kept across it.
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			state_r <= snc_pkg::SNC_SETTLE;
			tmr_r <= 8'h00;
			red_r <= 1'b0;
			green_r <= 1'b0;
			safe_r <= 1'b0;
			fault_r <= 1'b0;
			teach_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			red_r <= red_nxt;
			green_r <= green_nxt;
			safe_r <= safe_nxt;
			fault_r <= fault_nxt;
			teach_r <= teach_nxt;
		end
	end

	// Stored configuration. It stands for the non-volatile store, so it
	// is frozen while power-on reset is applied; only a teach-in
	// decision changes it, which lets a taught count survive power-ups.
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESET)
		begin
			stored_valid_r <= stored_valid_nxt;
			check_off_r <= check_off_nxt;
			stored_cnt_r <= stored_cnt_nxt;
		end
	end

	assign SAFE_ENABLE = safe_r;
	assign LED_RED = red_r;
	assign LED_GREEN = green_r;
	assign FAULT = fault_r;
	assign TEACH_ACTIVE = teach_r;
endmodule // snc_supervisor
`default_nettype wire

// file: testbench/snc_sup_asserts.sv
// Assertion checker for the node count supervisor outputs.
`timescale 1ns/1ps
`default_nettype none
module snc_sup_asserts
#(
	parameter int unsigned HALF_CYC = 4
)
(
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic SAFE_ENABLE,
	input wire logic LED_RED,
	input wire logic LED_GREEN,
	input wire logic FAULT,
	input wire logic TEACH_ACTIVE
);
	localparam int SAVE_LAST = snc_pkg::SAVE_CYC - 1;
	// Checks sleep while power-on reset is applied.
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	AST_RUN_GREEN: assert property (
		SAFE_ENABLE |-> LED_GREEN && !LED_RED && !FAULT)
		else $error("Run state indicator wrong.");
	AST_RUN_HOLD: assert property (
		SAFE_ENABLE |=> SAFE_ENABLE)
		else $error("Safe enable dropped.");
	AST_FAULT_RED: assert property (
		FAULT |-> LED_RED && !LED_GREEN && !SAFE_ENABLE)
		else $error("Fault indicator wrong.");
	AST_FAULT_HOLD: assert property (
		FAULT |=> FAULT)
		else $error("Fault cleared without power-up.");
	AST_SAVE_ALT: assert property (
		TEACH_ACTIVE |-> LED_RED != LED_GREEN && !SAFE_ENABLE)
		else $error("Saving colours do not alternate.");
	AST_SAVE_LEN: assert property (
		$rose(TEACH_ACTIVE) |->
		##SAVE_LAST TEACH_ACTIVE ##1 !TEACH_ACTIVE)
		else $error("Save length wrong.");
	// The LED must be lit again one half period after a low half of the blink begins.
	AST_RED_BLINK: assert property (
		$fell(LED_RED) && !LED_GREEN && !$past(TEACH_ACTIVE) |->
		##HALF_CYC LED_RED)
		else $error("Red blink period wrong.");
	AST_GRN_BLINK: assert property (
		$fell(LED_GREEN) && !LED_RED && !$past(TEACH_ACTIVE) |->
		##HALF_CYC LED_GREEN)
		else $error("Green blink period wrong.");
	// Nothing is enabled or lit in the first cycle after power-on reset ends.
	AST_RST_QUIET: assert property (
		$past(RESET) |->
		!SAFE_ENABLE && !LED_RED && !LED_GREEN && !FAULT && !TEACH_ACTIVE)
		else $error("Outputs active right after reset.");
endmodule // snc_sup_asserts
bind snc_supervisor snc_sup_asserts #(.HALF_CYC(HALF_CYC))
	snc_sup_asserts_inst
	(
		.SYS_CLK(SYS_CLK),
		.RESET(RESET),
		.SAFE_ENABLE(SAFE_ENABLE),
		.LED_RED(LED_RED),
		.LED_GREEN(LED_GREEN),
		.FAULT(FAULT),
		.TEACH_ACTIVE(TEACH_ACTIVE)
	);
`default_nettype wire

// file: testbench/snc_ctrl_model.sv
// Safety controller model driving the two test inputs.
`timescale 1ns/1ps
`default_nettype none
module snc_ctrl_model
(
	input wire logic clk,
	input wire logic teach,
	output logic first_out,
	output logic second_out
);
	logic [3:0] tick_r = 4'h0;
	// Free-running pulse pattern; the two outputs never match in normal wiring.
	always_ff @(posedge clk) tick_r <= tick_r + 4'h1;
	assign second_out = tick_r[3];
	assign first_out = teach ? tick_r[3] : ~tick_r[3];
endmodule // snc_ctrl_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the node count supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, rst = 1'b1, teach = 1'b0, term = 1'b0, valid = 1'b1;
	logic [5:0] cnt = 6'h00;
	logic fi, si, safe, red, grn, flt, act;
	logic [7:0] n_red, n_grn, n_safe, n_flt, n_act;
	int err_total = 0, compares = 0;
	// 100 MHz clock.
	initial forever #5 clk = ~clk;
	snc_ctrl_model snc_ctrl_model_inst (.clk(clk), .teach(teach),
		.first_out(fi), .second_out(si));
	snc_supervisor #(.HALF_CYC(4)) snc_supervisor_inst (.SYS_CLK(clk),
		.RESET(rst), .FIRST_TEST_INPUT(fi), .SECOND_TEST_INPUT(si),
		.NODE_COUNT(cnt), .TERMINATOR_SEEN(term), .COUNT_VALID(valid),
		.SAFE_ENABLE(safe), .LED_RED(red), .LED_GREEN(grn), .FAULT(flt),
		.TEACH_ACTIVE(act));
	task automatic finish_test();
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// A power cycle: chain results and wiring are set while reset is held.
	task automatic power(input logic t, input logic [5:0] c, input logic e);
		@(posedge clk);
		#1;
		teach = t;
		cnt = c;
		term = e;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
	endtask
	// Counts high samples over 16 cycles: a 1 Hz style blink gives 8 of 16.
	task automatic look();
		{n_red, n_grn, n_safe, n_flt, n_act} = '0;
		repeat (16)
		begin
			@(posedge clk);
			#1;
			n_red = n_red + {7'h00, red};
			n_grn = n_grn + {7'h00, grn};
			n_safe = n_safe + {7'h00, safe};
			n_flt = n_flt + {7'h00, flt};
			n_act = n_act + {7'h00, act};
		end
	endtask
	task automatic wait_act(input logic lvl);
		int n;
		n = 0;
		while (act !== lvl && n < 80)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({7'h00, act}, {7'h00, lvl});
	endtask
	task automatic run_norm(input logic [5:0] c, input logic [7:0] er,
		input logic [7:0] eg, input logic [7:0] ef);
		power(1'b0, c, 1'b1);
		repeat (40) @(posedge clk);
		look();
		chk(n_red, er);
		chk(n_grn, eg);
		chk(n_flt, ef);
		chk(n_safe, (eg == 8'h10) ? 8'h10 : 8'h00);
		$display("Normal power-up with %0d nodes done", c);
	endtask
	// The decision waits for a valid chain count; nothing shows meanwhile.
	task automatic run_late();
		valid = 1'b0;
		power(1'b0, 6'h05, 1'b1);
		repeat (40) @(posedge clk);
		look();
		chk(n_red | n_grn | n_safe | n_flt | n_act, 8'h00);
		valid = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		look();
		chk(n_grn, 8'h10);
		chk(n_safe, 8'h10);
		$display("Late count power-up done");
	endtask
	task automatic run_teach(input logic [5:0] c, input logic e,
		input logic [7:0] er, input logic [7:0] eg);
		power(1'b1, c, e);
		wait_act(1'b1);
		look();
		chk(n_act, 8'h10);
		chk(n_red, 8'h08);
		chk(n_grn, 8'h08);
		wait_act(1'b0);
		look();
		chk(n_red, er);
		chk(n_grn, eg);
		chk(n_safe, 8'h00);
		$display("Teach-in with %0d nodes done", c);
	endtask
	// Watchdog well beyond the expected run length.
	initial
	begin
		#200000;
		err_total++;
		finish_test();
	end
	// Main sequence of power-ups; the taught count survives each normal one.
	initial
	begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		run_norm(6'h05, 8'h08, 8'h00, 8'h00);
		run_teach(6'h05, 1'b1, 8'h00, 8'h08);
		run_norm(6'h05, 8'h00, 8'h10, 8'h00);
		run_late();
		run_norm(6'h04, 8'h10, 8'h00, 8'h10);
		run_teach(6'h03, 1'b1, 8'h00, 8'h08);
		run_norm(6'h03, 8'h00, 8'h10, 8'h00);
		run_norm(6'h05, 8'h10, 8'h00, 8'h10);
		run_teach(6'h03, 1'b0, 8'h08, 8'h00);
		run_norm(6'h03, 8'h08, 8'h00, 8'h00);
		run_teach(6'h00, 1'b1, 8'h00, 8'h08);
		run_norm(6'h07, 8'h00, 8'h10, 8'h00);
		finish_test();
	end
endmodule // tb
`default_nettype wire
